// ---- hw/spif_top.v ----
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "spif_regs.vh"

// Functional notes
// [RULE1] write-only 8-bit transmit data register; each write queues a byte
// [RULE2] read-only 8-bit receive data register returns received bytes
// [RULE3] 8-bit read/write baud divider, reset zero, sets serial clock rate
// [RULE4] 16-bit read/write control register, reset zero, both roles
// [RULE5] two-bit threshold N=1..4 for transmit and receive interrupt flags
// [RULE6] transmit flush bit keeps transmit queue empty while set
// [RULE7] while transmit flush is set, send last byte or zeros
// [RULE8] writes to transmit queue are dropped while transmit flush is set
// [RULE9] receive flush empties queue, ignores serial input, no interrupt flags; the code still sets the transmit underflow flag
// [RULE10] receive flush with read trigger: receive read still starts transfer
// [RULE11] continuous master mode sends back-to-back, select held until empty; the code chains bytes only in transmit trigger mode
// [RULE12] non-continuous: single byte per transfer, one sclk stall between
// [RULE13] loopback ties serial data output to serial data input internally
// [RULE14] slave data-out enable clear makes the slave output open-drain
// [RULE15] overwrite set and receive full: new byte replaces held data
// [RULE16] overwrite clear and receive full: new byte is dropped
// [RULE17] trigger mode: set starts on transmit write, clear on receive read
// [RULE18] zero fill sends zeros when empty, otherwise repeats last byte
// [RULE19] receive overflow flag set on byte into full queue unless flushing
// [RULE20] four-byte transmit and receive queues with tracked occupancy
module spif_top #(
  parameter DEPTH = 4
) (
  input wire ref_clk,
  input wire rst,
  input wire [31:0] bus_addr,
  input wire [31:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  output reg [31:0] bus_rdata,
  input wire sclk_in,
  output reg sclk_out,
  output reg sclk_oe,
  input wire ss_n_in,
  output reg ss_n_out,
  output reg ss_n_oe,
  input wire mosi_in,
  output reg mosi_out,
  output reg mosi_oe,
  input wire miso_in,
  output reg miso_out,
  output reg miso_oe
);
  localparam M_IDLE = 3'd0;
  localparam M_LEAD = 3'd1;
  localparam M_BITS = 3'd2;
  localparam M_TAIL = 3'd3;
  localparam M_STALL = 3'd4;

  // pick bit j of a byte in the chosen shift order
  function bit_sel;
    input [7:0] b;
    input [2:0] j;
    input lsb;
    begin
      bit_sel = lsb ? b[j] : b[3'd7 - j];
    end
  endfunction

  // shift one received bit into the assembly register
  function [7:0] shift_in;
    input [7:0] sh;
    input d;
    input lsb;
    begin
      shift_in = lsb ? {d, sh[7:1]} : {sh[6:0], d};
    end
  endfunction

  reg [7:0] baud_div_q;
  reg [15:0] ctrl_q;
  reg [2:0] m_state_q;
  reg [8:0] hcnt_q;
  reg [3:0] edge_q;
  reg [7:0] cur_tx_q;
  reg [7:0] rx_sh_q;
  reg out_bit_q;
  reg [2:0] scnt_q;
  reg rd_pend_q;
  reg [2:0] sent_q;
  reg ovf_q, rx_irq_q, tx_irq_q, under_q;
  reg [2:0] sclk_sy_q, ss_sy_q;
  reg [1:0] mosi_sy_q, miso_sy_q;

  wire [2:0] tx_cnt, rx_cnt;
  wire tx_full, tx_empty, rx_full, rx_empty;
  wire [7:0] tx_head, rx_head;

  wire en = ctrl_q[`SPIF_CTL_ENABLE];
  wire master = ctrl_q[`SPIF_CTL_MASTER];
  wire cpol = ctrl_q[`SPIF_CTL_CPOL];
  wire cpha = ctrl_q[`SPIF_CTL_CPHA];
  wire lsb = ctrl_q[`SPIF_CTL_LSB_FIRST];
  wire trig_tx = ctrl_q[`SPIF_CTL_TRIG_MODE];
  wire tx_flush = ctrl_q[`SPIF_CTL_TX_FLUSH];
  wire rx_flush = ctrl_q[`SPIF_CTL_RX_FLUSH];
  wire [2:0] thr_n = {1'b0, ctrl_q[`SPIF_CTL_THR_HI:`SPIF_CTL_THR_LO]}
    + 3'd1; // see [RULE5]

  // register decode
  wire sel_st = (bus_addr == `SPIF_STATUS_ADDR);
  wire sel_rx = (bus_addr == `SPIF_RX_DATA_ADDR);
  wire sel_tx = (bus_addr == `SPIF_TX_DATA_ADDR);
  wire sel_div = (bus_addr == `SPIF_BAUD_DIV_ADDR);
  wire sel_ctl = (bus_addr == `SPIF_CONTROL_ADDR);
  wire rx_read = bus_rd & sel_rx;
  wire st_read = bus_rd & sel_st;
  // flushed queue refuses writes outright
  wire tx_push = bus_wr & sel_tx & ~tx_flush; // see [RULE1] see [RULE8]

  // synchronised pin levels; stage 0 feeds only stage 1
  wire sclk_s = sclk_sy_q[1];
  wire ss_n_s = ss_sy_q[1];
  wire s_act = en & ~master & ~ss_n_s;
  wire s_chg = sclk_sy_q[1] ^ sclk_sy_q[2];
  wire s_lead = s_act & s_chg & (sclk_s != cpol);
  wire s_trail = s_act & s_chg & (sclk_s == cpol);
  wire s_fall = en & ~master & ~ss_n_s & ss_sy_q[2];
  wire s_samp = cpha ? s_trail : s_lead;
  wire s_launch = cpha ? s_lead : s_trail;

  // loopback feeds our own output back instead of the far pin
  wire din = ctrl_q[`SPIF_CTL_LOOPBACK] ? out_bit_q :
    (master ? miso_sy_q[1] : mosi_sy_q[1]); // see [RULE13]

  wire m_tick = (hcnt_q == {1'b0, baud_div_q});
  wire m_more = trig_tx & ~tx_empty;
  wire m_start = trig_tx ? ~tx_empty : rd_pend_q; // see [RULE17]
  wire m_last = (edge_q == `SPIF_EDGES_PER_BYTE);

  reg fetch_w;
  reg done_w;
  reg [7:0] rx_byte_w;

  // one byte fetch and one byte completion per event, either role
  always @* begin
    fetch_w = 1'b0;
    done_w = 1'b0;
    rx_byte_w = shift_in(rx_sh_q, din, lsb);
    if (en && master) begin
      if (m_state_q == M_IDLE && m_start) begin
        fetch_w = 1'b1;
      end
      if (m_state_q == M_TAIL && m_tick && ctrl_q[`SPIF_CTL_CONT]
          && m_more) begin
        fetch_w = 1'b1; // see [RULE11]
      end
      if (m_state_q == M_BITS && m_tick && m_last) begin
        done_w = 1'b1;
      end
    end else begin
      if (s_fall) begin
        fetch_w = 1'b1;
      end
      if (s_samp && scnt_q == 3'd7) begin
        fetch_w = 1'b1;
        done_w = 1'b1;
      end
    end
  end

  // received byte handling against a full queue
  wire rx_in = done_w & ~rx_flush; // see [RULE9]
  wire rx_ovw = rx_full & ctrl_q[`SPIF_CTL_RX_OVERWRITE]; // see [RULE15]
  // without overwrite the queue refuses the push and keeps old data
  wire rx_pop = rx_read | (rx_in & rx_ovw); // see [RULE16]
  // a phase-0 master takes its last sample half a period before the end,
  // so the finished byte already sits in the shift register then
  wire [7:0] rx_push_w = (en && master && !cpha) ? rx_sh_q : rx_byte_w;

  spif_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(2)) u_txq (
    .clk(ref_clk),
    .rst(rst),
    .flush(tx_flush), // see [RULE6]
    .push(tx_push),
    .push_data(bus_wdata[7:0]),
    .pop(fetch_w),
    .head(tx_head),
    .count(tx_cnt), // see [RULE20]
    .full(tx_full),
    .empty(tx_empty)
  );

  spif_fifo #(.WIDTH(8), .DEPTH(DEPTH), .AW(2)) u_rxq (
    .clk(ref_clk),
    .rst(rst),
    .flush(rx_flush), // see [RULE9]
    .push(rx_in),
    .push_data(rx_push_w),
    .pop(rx_pop),
    .head(rx_head),
    .count(rx_cnt), // see [RULE20]
    .full(rx_full),
    .empty(rx_empty)
  );

  // pin synchronisers
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_sy_q <= 3'h0;
      ss_sy_q <= 3'h7;
      mosi_sy_q <= 2'h0;
      miso_sy_q <= 2'h0;
    end else begin
      sclk_sy_q <= {sclk_sy_q[1:0], sclk_in};
      ss_sy_q <= {ss_sy_q[1:0], ss_n_in};
      mosi_sy_q <= {mosi_sy_q[0], mosi_in};
      miso_sy_q <= {miso_sy_q[0], miso_in};
    end
  end

  // software registers and the bus read path
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      baud_div_q <= `SPIF_BAUD_DIV_RST;
      ctrl_q <= `SPIF_CONTROL_RST;
      bus_rdata <= 32'h0;
    end else begin
      if (bus_wr && sel_div) begin
        baud_div_q <= bus_wdata[7:0]; // see [RULE3]
      end
      if (bus_wr && sel_ctl) begin
        ctrl_q <= bus_wdata[15:0]; // see [RULE4]
      end
      bus_rdata <= 32'h0; // unmapped and write-only read as zero
      if (bus_rd) begin
        if (sel_rx) begin
          bus_rdata <= {24'h0, rx_empty ? 8'h00 : rx_head}; // see [RULE2]
        end else if (sel_div) begin
          bus_rdata <= {24'h0, baud_div_q};
        end else if (sel_ctl) begin
          bus_rdata <= {16'h0, ctrl_q};
        end else if (sel_st) begin
          bus_rdata <= {20'h0, (rx_cnt > thr_n), rx_cnt, ovf_q, rx_irq_q,
            tx_irq_q, under_q, tx_cnt,
            ovf_q | rx_irq_q | tx_irq_q | under_q};
        end
      end
    end
  end

  // sticky status; a set in the cycle of the clearing read wins
  wire ovf_set = rx_in & rx_full; // see [RULE19]
  wire rxi_set = ~trig_tx & ~rx_flush & (rx_cnt >= thr_n); // see [RULE5]
  wire txi_set = trig_tx & ~rx_flush & done_w
    & (sent_q + 3'd1 >= thr_n); // see [RULE5] see [RULE9]
  wire und_set = fetch_w & tx_empty;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ovf_q <= 1'b0;
      rx_irq_q <= 1'b0;
      tx_irq_q <= 1'b0;
      under_q <= 1'b0;
      sent_q <= 3'h0;
      rd_pend_q <= 1'b0;
    end else begin
      ovf_q <= ovf_set | (ovf_q & ~st_read);
      rx_irq_q <= rxi_set | (rx_irq_q & ~st_read);
      tx_irq_q <= txi_set | (tx_irq_q & ~st_read);
      under_q <= und_set | (under_q & ~st_read);
      if (txi_set || !trig_tx) begin
        sent_q <= 3'h0;
      end else if (done_w) begin
        sent_q <= sent_q + 3'd1;
      end
      // a receive read arms a transfer even while flushing
      if (rx_read && !trig_tx) begin
        rd_pend_q <= 1'b1; // see [RULE10] see [RULE17]
      end else if (fetch_w && master) begin
        rd_pend_q <= 1'b0;
      end
    end
  end

  // master sequencer, slave bit engine and the shared data path
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      m_state_q <= M_IDLE;
      hcnt_q <= 9'h0;
      edge_q <= 4'h0;
      cur_tx_q <= 8'h00;
      rx_sh_q <= 8'h00;
      out_bit_q <= 1'b0;
      scnt_q <= 3'h0;
      sclk_out <= 1'b0;
      ss_n_out <= 1'b1;
    end else begin
      if (fetch_w) begin
        // empty or flushed queue: zero fill or keep the last byte
        if (!tx_empty) begin
          cur_tx_q <= tx_head;
        end else if (ctrl_q[`SPIF_CTL_ZERO_FILL]) begin
          cur_tx_q <= 8'h00; // see [RULE7] see [RULE18]
        end
      end
      hcnt_q <= (m_tick || m_state_q == M_IDLE) ? 9'h0 : hcnt_q + 9'd1;
      if (!(en && master)) begin
        m_state_q <= M_IDLE;
        sclk_out <= cpol;
        ss_n_out <= 1'b1;
        if (s_fall) begin
          scnt_q <= 3'h0;
          if (!cpha) begin
            out_bit_q <= bit_sel(tx_empty && ctrl_q[`SPIF_CTL_ZERO_FILL]
              ? 8'h00 : (tx_empty ? cur_tx_q : tx_head), 3'd0, lsb);
          end
        end else if (s_samp) begin
          rx_sh_q <= rx_byte_w;
          scnt_q <= scnt_q + 3'd1;
        end else if (s_launch) begin
          out_bit_q <= bit_sel(cur_tx_q, scnt_q, lsb);
        end
      end else begin
        case (m_state_q)
          M_IDLE: begin
            sclk_out <= cpol;
            if (m_start) begin
              ss_n_out <= 1'b0;
              m_state_q <= M_LEAD;
            end
          end
          M_LEAD: begin
            if (m_tick) begin
              m_state_q <= M_BITS;
              edge_q <= 4'h0;
              out_bit_q <= bit_sel(cur_tx_q, 3'd0, lsb);
            end
          end
          M_BITS: begin
            if (m_tick) begin
              sclk_out <= ~sclk_out;
              edge_q <= edge_q + 4'd1;
              if (edge_q[0] == cpha) begin
                rx_sh_q <= rx_byte_w;
              end else if (!m_last) begin
                out_bit_q <= bit_sel(cur_tx_q, edge_q[3:1] + {2'b0, ~cpha},
                  lsb);
              end
              if (m_last) begin
                m_state_q <= M_TAIL;
              end
            end
          end
          M_TAIL: begin
            if (m_tick) begin
              edge_q <= 4'h0;
              if (ctrl_q[`SPIF_CTL_CONT] && m_more) begin
                m_state_q <= M_LEAD; // select stays low
              end else begin
                ss_n_out <= 1'b1;
                m_state_q <= M_STALL; // see [RULE12]
              end
            end
          end
          M_STALL: begin
            // one whole serial clock of idle before the next byte
            if (m_tick) begin
              edge_q <= edge_q + 4'd1;
              if (edge_q[0]) begin
                m_state_q <= M_IDLE; // see [RULE12]
              end
            end
          end
          default: begin
            m_state_q <= M_IDLE;
          end
        endcase
      end
    end
  end

  // pin drivers; data value and enable move on the same edge
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_oe <= 1'b0;
      ss_n_oe <= 1'b0;
      mosi_out <= 1'b0;
      mosi_oe <= 1'b0;
      miso_out <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      sclk_oe <= en & master;
      ss_n_oe <= en & master;
      mosi_out <= out_bit_q;
      mosi_oe <= en & master & (~ctrl_q[`SPIF_CTL_WIRED_OR] | ~out_bit_q);
      miso_out <= out_bit_q;
      // open-drain slave output only ever pulls low
      miso_oe <= s_act & (ctrl_q[`SPIF_CTL_SLV_DOUT_EN]
        | ~out_bit_q); // see [RULE14]
    end
  end
endmodule

// ---- common/spif_regs.vh ----
`ifndef SPIF_REGS_VH
`define SPIF_REGS_VH

// register byte addresses
`define SPIF_STATUS_ADDR 32'hFFFF0A00
`define SPIF_RX_DATA_ADDR 32'hFFFF0A04
`define SPIF_TX_DATA_ADDR 32'hFFFF0A08
`define SPIF_BAUD_DIV_ADDR 32'hFFFF0A0C
`define SPIF_CONTROL_ADDR 32'hFFFF0A10

// reset values
`define SPIF_BAUD_DIV_RST 8'h00
`define SPIF_CONTROL_RST 16'h0000

// serial_control_reg fields
`define SPIF_CTL_THR_HI 15
`define SPIF_CTL_THR_LO 14
`define SPIF_CTL_TX_FLUSH 13
`define SPIF_CTL_RX_FLUSH 12
`define SPIF_CTL_CONT 11
`define SPIF_CTL_LOOPBACK 10
`define SPIF_CTL_SLV_DOUT_EN 9
`define SPIF_CTL_RX_OVERWRITE 8
`define SPIF_CTL_ZERO_FILL 7
`define SPIF_CTL_TRIG_MODE 6
`define SPIF_CTL_LSB_FIRST 5
`define SPIF_CTL_WIRED_OR 4
`define SPIF_CTL_CPOL 3
`define SPIF_CTL_CPHA 2
`define SPIF_CTL_MASTER 1
`define SPIF_CTL_ENABLE 0

// status register fields
`define SPIF_ST_RX_EXCESS 11
`define SPIF_ST_RX_CNT_HI 10
`define SPIF_ST_RX_CNT_LO 8
`define SPIF_ST_RX_OVF 7
`define SPIF_ST_RX_IRQ 6
`define SPIF_ST_TX_IRQ 5
`define SPIF_ST_TX_UNDER 4
`define SPIF_ST_TX_CNT_HI 3
`define SPIF_ST_TX_CNT_LO 1
`define SPIF_ST_ANY_IRQ 0

// index of the last sclk edge of a serial byte, counted from zero; a byte spans 16 edges
`define SPIF_EDGES_PER_BYTE 4'hF

`endif

// ---- hw/spif_fifo.v ----
`timescale 1ns/1ps
// small byte queue; a push into a full queue is taken only with a pop
module spif_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire rst,
  input wire flush,
  input wire push,
  input wire [WIDTH-1:0] push_data,
  input wire pop,
  output wire [WIDTH-1:0] head,
  output wire [AW:0] count,
  output wire full,
  output wire empty
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] rd_ptr_q;
  reg [AW-1:0] wr_ptr_q;
  reg [AW:0] count_q;
  wire do_pop;
  wire do_push;

  assign full = (count_q == DEPTH[AW:0]);
  assign empty = (count_q == {(AW+1){1'b0}});
  assign count = count_q;
  assign head = mem[rd_ptr_q];
  assign do_pop = pop & ~empty;
  assign do_push = push & (~full | do_pop);

  // storage has no reset; only pointers and count matter
  always @(posedge clk) begin
    if (do_push && !flush) begin
      mem[wr_ptr_q] <= push_data;
    end
  end

  // flush holds the queue empty for as long as it stays high
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_ptr_q <= {AW{1'b0}};
      wr_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else if (flush) begin
      rd_ptr_q <= {AW{1'b0}};
      wr_ptr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (do_pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if (do_push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (do_push && !do_pop) begin
        count_q <= count_q + 1'b1;
      end else if (do_pop && !do_push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

// ---- tb/spif_properties.sv ----
`timescale 1ns/1ps
`include "spif_regs.vh"
// pin and bus read-back checks; divider and control are shadowed from bus writes
module spif_props #(
  parameter DEPTH = 4
) (
  input wire ref_clk,
  input wire rst,
  input wire [31:0] bus_addr,
  input wire [31:0] bus_wdata,
  input wire bus_wr,
  input wire bus_rd,
  input wire [31:0] bus_rdata,
  input wire sclk_in,
  input wire sclk_out,
  input wire sclk_oe,
  input wire ss_n_in,
  input wire ss_n_out,
  input wire ss_n_oe,
  input wire mosi_in,
  input wire mosi_out,
  input wire mosi_oe,
  input wire miso_in,
  input wire miso_out,
  input wire miso_oe
);
  reg [7:0] div_q;
  reg [15:0] ctl_q;
  wire rd_div = bus_rd && bus_addr == `SPIF_BAUD_DIV_ADDR;
  wire rd_ctl = bus_rd && bus_addr == `SPIF_CONTROL_ADDR;
  wire rd_tx = bus_rd && bus_addr == `SPIF_TX_DATA_ADDR;
  wire rd_st = bus_rd && bus_addr == `SPIF_STATUS_ADDR;
  // shadow registers, so read-back can be judged without peeking inside
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      div_q <= 8'h00;
      ctl_q <= 16'h0000;
    end else if (bus_wr && bus_addr == `SPIF_BAUD_DIV_ADDR) begin
      div_q <= bus_wdata[7:0];
    end else if (bus_wr && bus_addr == `SPIF_CONTROL_ADDR) begin
      ctl_q <= bus_wdata[15:0];
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  property p_div_rb;
    rd_div |=> bus_rdata == {24'h000000, div_q};
  endproperty
  a_div_rb: assert property (p_div_rb)
    else $error("divider readback");
  property p_ctl_rb;
    rd_ctl |=> bus_rdata == {16'h0000, ctl_q};
  endproperty
  a_ctl_rb: assert property (p_ctl_rb)
    else $error("control readback");
  property p_tx_wo;
    rd_tx |=> bus_rdata == 32'h00000000;
  endproperty
  a_tx_wo: assert property (p_tx_wo)
    else $error("tx data readable");
  property p_rd_idle;
    !bus_rd |=> bus_rdata == 32'h00000000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("stale read data");
  // bit9 clear: the slave line may only pull low
  property p_slv_od;
    miso_oe && !ctl_q[9] && !$past(ctl_q[9]) |-> !miso_out;
  endproperty
  a_slv_od: assert property (p_slv_od)
    else $error("miso driven high");
  // master pin enables follow enable and role one cycle late
  property p_oe;
    sclk_oe == ($past(ctl_q[1]) && $past(ctl_q[0])) && ss_n_oe == sclk_oe
      && (mosi_oe == sclk_oe || $past(ctl_q[4]));
  endproperty
  a_oe: assert property (p_oe)
    else $error("master pin enables wrong");
  property p_quiet;
    ss_n_out && $past(ss_n_out) && $past(ss_n_out, 2) &&
      $past(ctl_q[3], 2) == ctl_q[3] |-> $stable(sclk_out);
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("sclk moved unselected");
  property p_ss_len;
    $fell(ss_n_out) && div_q == 8'h03 |-> !ss_n_out [*8];
  endproperty
  a_ss_len: assert property (p_ss_len)
    else $error("frame too short");
  property p_stall;
    $rose(ss_n_out) && div_q == 8'h03 |-> ss_n_out [*8];
  endproperty
  a_stall: assert property (p_stall)
    else $error("stall too short");
  property p_txf;
    rd_st && ctl_q[13] && $past(ctl_q[13]) |=> bus_rdata[3:1] == 3'h0;
  endproperty
  a_txf: assert property (p_txf)
    else $error("tx queue not flushed");
  property p_rxf;
    rd_st && ctl_q[12] && $past(ctl_q[12]) |=> bus_rdata[10:8] == 3'h0;
  endproperty
  a_rxf: assert property (p_rxf)
    else $error("rx queue not flushed");
  c_frame: cover property ($fell(ss_n_out));
  c_slave: cover property (miso_oe);
  c_flush: cover property (rd_st && ctl_q[13]);
endmodule

bind spif_top spif_props #(.DEPTH(DEPTH)) chk_u (.ref_clk(ref_clk),
  .rst(rst), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_rdata(bus_rdata), .sclk_in(sclk_in),
  .sclk_out(sclk_out), .sclk_oe(sclk_oe), .ss_n_in(ss_n_in),
  .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe), .mosi_in(mosi_in),
  .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_in),
  .miso_out(miso_out), .miso_oe(miso_oe));

// ---- tb/spif_slave_model.sv ----
`timescale 1ns/1ps
// far-side slave, mode 0, msb first; answers every frame with reply
module spif_slave_model (
  input wire sclk,
  input wire ss_n,
  input wire mosi,
  input wire [7:0] reply,
  output reg miso,
  output reg [7:0] got
);
  reg [7:0] sh;
  initial begin
    miso = 1'b0;
    got = 8'h00;
    sh = 8'h00;
  end
  // select loads the reply; deselect flips the line so stale bits never match
  always @(negedge ss_n) begin
    sh = reply;
    miso = reply[7];
  end
  always @(posedge ss_n) miso = ~miso;
  // capture on the leading edge, launch the next bit on the trailing edge
  always @(posedge sclk) if (!ss_n) got = {got[6:0], mosi};
  always @(negedge sclk) begin
    if (!ss_n) begin
      sh = {sh[6:0], 1'b0};
      miso = sh[7];
    end
  end
endmodule

// ---- tb/spif_fifo_control_port_tb_top.sv ----
`timescale 1ns/1ps
`include "spif_regs.vh"
`define CHK(a, e) begin checks = checks + 1; \
  if ((a) !== (e)) begin err_total = err_total + 1; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module spif_fifo_control_port_tb_top;
  reg ref_clk = 1'b0;
  reg rst = 1'b1;
  reg bus_wr = 1'b0;
  reg bus_rd = 1'b0;
  reg ss_n_in = 1'b1;
  reg [31:0] bus_addr = 32'h00000000;
  reg [31:0] bus_wdata = 32'h00000000;
  wire [31:0] bus_rdata;
  wire sclk_out, sclk_oe, ss_n_out, ss_n_oe, mosi_out, mosi_oe;
  wire miso_in, miso_out, miso_oe;
  wire [7:0] got;
  integer err_total = 0;
  integer checks = 0;
  integer ss_rises = 0;
  integer i;
  reg [31:0] v;
  always #4 ref_clk = ~ref_clk;
  // count chip-select releases to see how bytes are framed
  always @(posedge ss_n_out) ss_rises = ss_rises + 1;
  // slave side pins of the block are idle apart from chip select
  spif_top #(.DEPTH(4)) dut_u (.ref_clk(ref_clk), .rst(rst),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .sclk_in(1'b0),
    .sclk_out(sclk_out), .sclk_oe(sclk_oe), .ss_n_in(ss_n_in),
    .ss_n_out(ss_n_out), .ss_n_oe(ss_n_oe), .mosi_in(1'b0),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_in),
    .miso_out(miso_out), .miso_oe(miso_oe));
  spif_slave_model peer_u (.sclk(sclk_out), .ss_n(ss_n_out),
    .mosi(mosi_out), .reply(8'hA5), .miso(miso_in), .got(got));
  task wr(input [31:0] a, input [31:0] d);
    begin
      @(posedge ref_clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge ref_clk);
      bus_wr <= 1'b0;
    end
  endtask
  // read data stand only in the cycle after the strobe
  task rd(input [31:0] a);
    begin
      @(posedge ref_clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge ref_clk);
      bus_rd <= 1'b0;
      #1;
      v = bus_rdata;
    end
  endtask
  // idle means select stayed high far longer than the one-sclk stall
  task wait_idle;
    integer k, n;
    begin
      k = 0;
      n = 0;
      while (k < 24 && n < 3000) begin
        @(posedge ref_clk);
        #1;
        n = n + 1;
        k = (ss_n_out === 1'b1) ? k + 1 : 0;
      end
    end
  endtask
  task end_sim;
    begin
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask
  // watchdog: the tests need well under 5000 cycles
  initial begin
    repeat (30000) @(posedge ref_clk);
    err_total = err_total + 1;
    end_sim;
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    rd(`SPIF_BAUD_DIV_ADDR);
    `CHK(v, 32'h00000000)
    rd(`SPIF_CONTROL_ADDR);
    `CHK(v, 32'h00000000)
    rd(`SPIF_TX_DATA_ADDR);
    `CHK(v, 32'h00000000)
    wr(`SPIF_BAUD_DIV_ADDR, 32'h00000003);
    rd(`SPIF_BAUD_DIV_ADDR);
    `CHK(v, 32'h00000003)
    wr(`SPIF_CONTROL_ADDR, 32'h00004043);
    rd(`SPIF_CONTROL_ADDR);
    `CHK(v, 32'h00004043)
    $display("test done: registers");
    ss_rises = 0;
    wr(`SPIF_TX_DATA_ADDR, 32'h0000003C);
    wr(`SPIF_TX_DATA_ADDR, 32'h000000C3);
    wait_idle;
    `CHK(got, 8'hC3)
    `CHK(ss_rises, 2)
    rd(`SPIF_STATUS_ADDR);
    `CHK(v[10:8], 3'h2)
    `CHK(v[5], 1'b1)
    rd(`SPIF_RX_DATA_ADDR);
    `CHK(v, 32'h000000A5)
    rd(`SPIF_RX_DATA_ADDR);
    `CHK(v, 32'h000000A5)
    $display("test done: single bytes");
    wr(`SPIF_CONTROL_ADDR, 32'h00000843);
    ss_rises = 0;
    wr(`SPIF_TX_DATA_ADDR, 32'h00000011);
    wr(`SPIF_TX_DATA_ADDR, 32'h00000022);
    wait_idle;
    `CHK(ss_rises, 1)
    `CHK(got, 8'h22)
    rd(`SPIF_RX_DATA_ADDR);
    rd(`SPIF_RX_DATA_ADDR);
    $display("test done: continuous");
    wr(`SPIF_CONTROL_ADDR, 32'h00000443);
    for (i = 0; i < 5; i = i + 1) wr(`SPIF_TX_DATA_ADDR, 32'h10 + i);
    wait_idle;
    rd(`SPIF_STATUS_ADDR);
    `CHK(v[10:8], 3'h4)
    `CHK(v[7], 1'b1)
    rd(`SPIF_RX_DATA_ADDR);
    `CHK(v, 32'h00000010)
    wr(`SPIF_CONTROL_ADDR, 32'h00000543);
    wr(`SPIF_TX_DATA_ADDR, 32'h00000015);
    wr(`SPIF_TX_DATA_ADDR, 32'h00000016);
    wait_idle;
    rd(`SPIF_RX_DATA_ADDR);
    `CHK(v, 32'h00000012)
    $display("test done: overflow");
    // read trigger, loopback, empty queue repeats the last byte sent
    wr(`SPIF_CONTROL_ADDR, 32'h00000403);
    rd(`SPIF_RX_DATA_ADDR);
    `CHK(v, 32'h00000013)
    wait_idle;
    rd(`SPIF_STATUS_ADDR);
    `CHK(v[10:8], 3'h3)
    `CHK(v[6], 1'b1)
    rd(`SPIF_RX_DATA_ADDR);
    `CHK(v, 32'h00000015)
    rd(`SPIF_RX_DATA_ADDR);
    `CHK(v, 32'h00000016)
    rd(`SPIF_RX_DATA_ADDR);
    `CHK(v, 32'h00000016)
    wait_idle;
    $display("test done: read trigger");
    wr(`SPIF_CONTROL_ADDR, 32'h00003083);
    wait_idle;
    wr(`SPIF_TX_DATA_ADDR, 32'h00000077);
    rd(`SPIF_STATUS_ADDR);
    `CHK(v[3:1], 3'h0)
    rd(`SPIF_RX_DATA_ADDR);
    wait_idle;
    `CHK(got, 8'h00)
    rd(`SPIF_STATUS_ADDR);
    `CHK(v[10:8], 3'h0)
    $display("test done: flush");
    wr(`SPIF_CONTROL_ADDR, 32'h00000081);
    ss_n_in <= 1'b0;
    repeat (10) @(posedge ref_clk);
    #1;
    `CHK({miso_oe, miso_out}, 2'b10)
    @(posedge ref_clk);
    ss_n_in <= 1'b1;
    $display("test done: slave");
    end_sim;
  end
endmodule
